// ===== src/sdrm_cfg.svh
// Constants for the SDRAM init and mode register block
`ifndef SDRM_CFG_SVH
`define SDRM_CFG_SVH
// ==========================================================
// Mode word fields
`define SDRM_F_BL      2:0
`define SDRM_F_BT      3
`define SDRM_F_CL      6:4
`define SDRM_F_OPM     12:7
`define SDRM_F_WSINGLE 9
`define SDRM_F_ALLBANK 10
`define SDRM_F_LOBYTE  7:0
`define SDRM_F_HIBYTE  15:8
// ==========================================================
// Field codes
`define SDRM_BL_1      3'h0
`define SDRM_BL_2      3'h1
`define SDRM_BL_4      3'h2
`define SDRM_BL_8      3'h3
`define SDRM_BL_PAGE   3'h7
`define SDRM_CL_2      3'h2
`define SDRM_CL_3      3'h3
`define SDRM_OPM_BURST 6'h00
`define SDRM_OPM_SINGL 6'h04
`define SDRM_BA_MODE   2'h0
`define SDRM_MASK_HI   2'h3
// ==========================================================
// Controller register offsets and fields
`define SDRM_REG_CTRL  8'h00
`define SDRM_REG_MODE  8'h04
`define SDRM_REG_STAT  8'h08
`define SDRM_REG_CMD   8'h0C
`define SDRM_REG_ADDR  8'h10
`define SDRM_REG_WDAT  8'h14
`define SDRM_REG_RDAT  8'h18
`define SDRM_CMD_CODE  2:0
`define SDRM_CMD_BA    4:3
`define SDRM_CMD_DQM   6:5
// ==========================================================
// Timing
`define SDRM_PAUSE_MS  200
`define SDRM_CLK_NS    8
`define SDRM_NS_PER_MS 1000000
`define SDRM_REF_COUNT 8
`define SDRM_REF_GAP   8
`endif

// ===== src/sdrm_pkg.sv
// Types shared by both ends of the SDRAM link
package sdrm_pkg;
   // Command code as {rasN, casN, weN}
   typedef enum logic [2:0] {
      CMD_MRS = 3'h0,
      CMD_REF = 3'h1,
      CMD_PRE = 3'h2,
      CMD_ACT = 3'h3,
      CMD_WR  = 3'h4,
      CMD_RD  = 3'h5,
      CMD_BST = 3'h6,
      CMD_NOP = 3'h7
   } sdrm_cmd_t;
   typedef enum {
      ST_IDLE, ST_PAUSE, ST_PRE, ST_REF, ST_WAIT, ST_MRS, ST_MNOP, ST_READY
   } sdrm_state_t;
endpackage : sdrm_pkg

// ===== src/sdrm_if.sv
// Pin-level link between SDRAM controller and SDRAM device
`timescale 1ns/1ps
`default_nettype none
interface sdrm_if;
   logic        cke;
   logic        csN;
   logic        rasN;
   logic        casN;
   logic        weN;
   logic [1:0]  ba;
   logic [12:0] addr;
   logic        upperByteMask;
   logic        lowerByteMask;
   logic [15:0] dqCtrl;
   logic        dqCtrlOe;
   logic [15:0] dqDev;
   logic [1:0]  dqDevOe;
   logic [15:0] dqBus;
   // Resolved data bus level per byte lane
   assign dqBus[15:8] = dqDevOe[1] ? dqDev[15:8] :
                        (dqCtrlOe ? dqCtrl[15:8] : 8'h00);
   assign dqBus[7:0]  = dqDevOe[0] ? dqDev[7:0] :
                        (dqCtrlOe ? dqCtrl[7:0] : 8'h00);
   modport ctrl (output cke, csN, rasN, casN, weN, ba, addr,
                 upperByteMask, lowerByteMask, dqCtrl, dqCtrlOe,
                 input dqBus);
   modport dev (input cke, csN, rasN, casN, weN, ba, addr,
                upperByteMask, lowerByteMask, dqBus,
                output dqDev, dqDevOe);
endinterface : sdrm_if
`default_nettype wire

// ===== src/sdrm_device.sv
// SDRAM device end: banks, mode register, bursts and byte masks
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sdrm_cfg.svh"
// Summary of operation
// R1: Read mask disables output, latency two
// R2: Write mask blocks byte, latency zero
// R3: Upper mask upper byte, lower mask lower
// R4: Four banks, 4M words by 16
// R5: Controller holds NOP while powering
// R6: Controller runs clock from power on
// R7: Controller pauses 200 ms, then precharges
// R8: Masks and clock enable high in pause
// R9: Mode set plus eight auto refreshes
// R10: Mode register always programmed explicitly
// R11: Mode set before any activate
// R12: Banks precharged, enable high before set
// R13: NOP follows every mode set
// R14: RAS CAS WE low loads mode
// R15: Bank select zero targets mode register
// R16: New mode set overwrites whole register
// R17: Burst length field decode, bits 2:0
// R18: Bit 3 picks sequential or interleaved
// R19: Read latency field, two or three
// R20: Operating mode field, bits 12:7
// R21: First read word at edge n+m
// R22: Bursts wrap within aligned column block
module sdrm_device
   import sdrm_pkg::*;
#(
   parameter int ROW_W = 13,
   parameter int COL_W = 9,
   parameter int BANKS = 4
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   sdrm_if.dev              bus,
   output logic [12:0]      modeWord,
   output logic             modeValid,
   output logic             modeReserved,
   output logic [BANKS-1:0] bankOpen
);
   localparam int AW = $clog2(BANKS) + ROW_W + COL_W;
   localparam int BW = $clog2(BANKS);

   // ==========================================================
   // Helpers
   // R17 burst length decode
   function automatic logic [COL_W-1:0] lastIdx(input logic [12:0] m);
      case (m[`SDRM_F_BL])
         `SDRM_BL_2:    lastIdx = COL_W'(1);
         `SDRM_BL_4:    lastIdx = COL_W'(3);
         `SDRM_BL_8:    lastIdx = COL_W'(7);
         `SDRM_BL_PAGE: lastIdx = '1;
         default:       lastIdx = '0;
      endcase
   endfunction : lastIdx

   // R22 column within aligned block; R18 burst order
   function automatic logic [COL_W-1:0] colAt(
      input logic [COL_W-1:0] start,
      input logic [COL_W-1:0] idx,
      input logic [COL_W-1:0] lmask,
      input logic             inter
   );
      logic [COL_W-1:0] low;
      low = inter ? (start ^ idx) : COL_W'(start + idx);
      colAt = (start & ~lmask) | (low & lmask);
   endfunction : colAt

   function automatic logic [AW-1:0] memAddr(
      input logic [BW-1:0]    b,
      input logic [ROW_W-1:0] r,
      input logic [COL_W-1:0] c
   );
      memAddr = {b, r, c};
   endfunction : memAddr

   // ==========================================================
   // Storage
   // R4 four banks of rows by columns by 16
   logic [15:0]      mem [2**AW];
   logic [12:0]      mode_r;
   logic             modeValid_r;
   logic [ROW_W-1:0] bankRow_r [BANKS];
   logic [BANKS-1:0] bankOpen_r;

   // Burst state
   logic             bActive_r;
   logic             bWrite_r;
   logic [BW-1:0]    bBank_r;
   logic [ROW_W-1:0] bRow_r;
   logic [COL_W-1:0] bStart_r;
   logic [COL_W-1:0] bIdx_r;
   logic [COL_W-1:0] bLast_r;

   // Read pipeline
   logic [15:0]      rdWord0_r;
   logic [15:0]      rdWord1_r;
   logic             rdVal0_r;
   logic             rdVal1_r;
   logic [15:0]      dqOut_r;
   logic [1:0]       mask1_r;
   logic [1:0]       dqOe_r;

   // ==========================================================
   // Command decode
   sdrm_cmd_t        cmd;
   logic             isRw;
   logic [COL_W-1:0] cmdLast;
   logic             accValid;
   logic             accWrite;
   logic [AW-1:0]    accAddr;
   logic [1:0]       laneMask;

   // R14 RAS CAS WE sampled at rising edge
   always_comb begin
      if (!bus.csN && bus.cke) begin
         cmd = sdrm_cmd_t'({bus.rasN, bus.casN, bus.weN});
      end else begin
         cmd = CMD_NOP;
      end
   end

   assign isRw = (cmd == CMD_RD) || (cmd == CMD_WR);
   // R3 upper mask on bit 1, lower on bit 0
   assign laneMask = {bus.upperByteMask, bus.lowerByteMask};

   // R20 single-location writes when mode bit set
   always_comb begin
      if (cmd == CMD_WR && mode_r[`SDRM_F_WSINGLE]) begin
         cmdLast = '0;
      end else begin
         cmdLast = lastIdx(mode_r);
      end
   end

   // Current access: a new read or write command wins over a running burst
   always_comb begin
      accValid = 1'b0;
      accWrite = 1'b0;
      accAddr  = '0;
      if (isRw) begin
         accValid = 1'b1;
         accWrite = (cmd == CMD_WR);
         accAddr  = memAddr(bus.ba[BW-1:0], bankRow_r[bus.ba[BW-1:0]],
                            bus.addr[COL_W-1:0]);
      end else if (bActive_r && cmd != CMD_BST && cmd != CMD_PRE) begin
         accValid = 1'b1;
         accWrite = bWrite_r;
         accAddr  = memAddr(bBank_r, bRow_r,
                            colAt(bStart_r, bIdx_r, bLast_r,
                                  mode_r[`SDRM_F_BT]));
      end
   end

   // ==========================================================
   // Mode register
   // R14 R15 R16 whole word loaded on mode set to bank zero
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_r      <= '0;
         modeValid_r <= 1'b0;
      end else if (cmd == CMD_MRS && bus.ba == `SDRM_BA_MODE) begin
         mode_r      <= bus.addr;
         modeValid_r <= 1'b1;
      end
   end

   // ==========================================================
   // Bank rows
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bankOpen_r <= '0;
      end else if (cmd == CMD_ACT) begin
         bankOpen_r[bus.ba[BW-1:0]] <= 1'b1;
      end else if (cmd == CMD_PRE && bus.addr[`SDRM_F_ALLBANK]) begin
         bankOpen_r <= '0;
      end else if (cmd == CMD_PRE) begin
         bankOpen_r[bus.ba[BW-1:0]] <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (cmd == CMD_ACT) begin
         bankRow_r[bus.ba[BW-1:0]] <= bus.addr[ROW_W-1:0];
      end
   end

   // ==========================================================
   // Burst sequencing
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bActive_r <= 1'b0;
         bWrite_r  <= 1'b0;
         bBank_r   <= '0;
         bRow_r    <= '0;
         bStart_r  <= '0;
         bIdx_r    <= '0;
         bLast_r   <= '0;
      end else if (isRw) begin
         bActive_r <= (cmdLast != '0);
         bWrite_r  <= (cmd == CMD_WR);
         bBank_r   <= bus.ba[BW-1:0];
         bRow_r    <= bankRow_r[bus.ba[BW-1:0]];
         bStart_r  <= bus.addr[COL_W-1:0];
         bIdx_r    <= COL_W'(1);
         bLast_r   <= cmdLast;
      end else if (cmd == CMD_BST || cmd == CMD_PRE) begin
         bActive_r <= 1'b0;
      end else if (bActive_r) begin
         bIdx_r    <= COL_W'(bIdx_r + COL_W'(1));
         bActive_r <= (bIdx_r != bLast_r);
      end
   end

   // ==========================================================
   // Array write
   // R2 write mask acts in the same cycle
   always_ff @(posedge sys_clk) begin
      if (accValid && accWrite && !laneMask[0]) begin
         mem[accAddr][`SDRM_F_LOBYTE] <= bus.dqBus[`SDRM_F_LOBYTE];
      end
      if (accValid && accWrite && !laneMask[1]) begin
         mem[accAddr][`SDRM_F_HIBYTE] <= bus.dqBus[`SDRM_F_HIBYTE];
      end
   end

   // ==========================================================
   // Read path
   // R21 R19 first word driven for edge n plus latency
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdWord0_r <= '0;
         rdWord1_r <= '0;
         rdVal0_r  <= 1'b0;
         rdVal1_r  <= 1'b0;
         dqOut_r   <= '0;
      end else begin
         rdWord0_r <= mem[accAddr];
         rdVal0_r  <= accValid && !accWrite;
         rdWord1_r <= rdWord0_r;
         rdVal1_r  <= rdVal0_r;
         if (mode_r[`SDRM_F_CL] == `SDRM_CL_3) begin
            dqOut_r <= rdWord1_r;
         end else begin
            dqOut_r <= rdWord0_r;
         end
      end
   end

   // R1 mask sampled two edges before data edge
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mask1_r <= `SDRM_MASK_HI;
         dqOe_r  <= '0;
      end else begin
         mask1_r <= laneMask;
         if (mode_r[`SDRM_F_CL] == `SDRM_CL_3) begin
            dqOe_r <= {2{rdVal1_r}} & ~mask1_r;
         end else begin
            dqOe_r <= {2{rdVal0_r}} & ~mask1_r;
         end
      end
   end

   // ==========================================================
   // Outputs
   assign bus.dqDev     = dqOut_r;
   assign bus.dqDevOe   = dqOe_r;
   assign modeWord      = mode_r;
   assign modeValid     = modeValid_r;
   assign bankOpen      = bankOpen_r;

   // R17 R19 R20 reserved code flag
   logic reserved_r;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reserved_r <= 1'b0;
      end else begin
         reserved_r <= (lastIdx(mode_r) == '0 &&
                        mode_r[`SDRM_F_BL] != `SDRM_BL_1) ||
                       (mode_r[`SDRM_F_BL] == `SDRM_BL_PAGE &&
                        mode_r[`SDRM_F_BT]) ||
                       (mode_r[`SDRM_F_CL] != `SDRM_CL_2 &&
                        mode_r[`SDRM_F_CL] != `SDRM_CL_3) ||
                       (mode_r[`SDRM_F_OPM] != `SDRM_OPM_BURST &&
                        mode_r[`SDRM_F_OPM] != `SDRM_OPM_SINGL);
      end
   end
   assign modeReserved = reserved_r;
endmodule : sdrm_device
`default_nettype wire

// ===== src/sdrm_ctrl.sv
// SDRAM controller end: power-up sequence and raw command port
`timescale 1ns/1ps
`default_nettype none
`include "sdrm_cfg.svh"
module sdrm_ctrl
   import sdrm_pkg::*;
#(
   parameter int PAUSE_CYC = `SDRM_PAUSE_MS * (`SDRM_NS_PER_MS / `SDRM_CLK_NS),
   parameter int REF_GAP   = `SDRM_REF_GAP,
   parameter int REF_NUM   = `SDRM_REF_COUNT
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   sdrm_if.ctrl             bus,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [31:0]      regRdata
);
   sdrm_state_t state_r;
   logic [31:0] cnt_r;
   logic [3:0]  refCnt_r;
   logic [12:0] mode_r;
   logic [12:0] addrReg_r;
   logic [15:0] wdat_r;
   logic [15:0] rdat_r;
   logic        rdValid_r;
   logic [2:0]  rdCnt_r;
   logic        lastMrs_r;
   logic [31:0] regRdata_r;
   logic        cke_r;
   logic [2:0]  cmd_r;
   logic [1:0]  ba_r;
   logic [12:0] pinAddr_r;
   logic [1:0]  dqm_r;
   logic        dqOe_r;
   logic        cmdWr;

   // Raw command accepted only when ready and not right after a mode set
   assign cmdWr = regWr && regAddr == `SDRM_REG_CMD &&
                  state_r == ST_READY && !lastMrs_r;

   // ==========================================================
   // Software registers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_r    <= '0;
         addrReg_r <= '0;
         wdat_r    <= '0;
      end else if (regWr) begin
         case (regAddr)
            `SDRM_REG_MODE: mode_r    <= regWdata[12:0];
            `SDRM_REG_ADDR: addrReg_r <= regWdata[12:0];
            `SDRM_REG_WDAT: wdat_r    <= regWdata[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         regRdata_r <= '0;
      end else if (regRd) begin
         case (regAddr)
            `SDRM_REG_MODE: regRdata_r <= {19'h0_0000, mode_r};
            `SDRM_REG_STAT: regRdata_r <= {29'h0000_0000, rdValid_r,
                                           state_r == ST_READY,
                                           state_r != ST_IDLE &&
                                           state_r != ST_READY};
            `SDRM_REG_ADDR: regRdata_r <= {19'h0_0000, addrReg_r};
            `SDRM_REG_WDAT: regRdata_r <= {16'h0000, wdat_r};
            `SDRM_REG_RDAT: regRdata_r <= {16'h0000, rdat_r};
            default:        regRdata_r <= '0;
         endcase
      end else begin
         regRdata_r <= '0;
      end
   end
   assign regRdata = regRdata_r;

   // ==========================================================
   // Power-up sequence
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r  <= ST_IDLE;
         cnt_r    <= '0;
         refCnt_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (regWr && regAddr == `SDRM_REG_CTRL && regWdata[0]) begin
                  state_r <= ST_PAUSE;
                  cnt_r   <= '0;
               end
            end
            // R7 R8 pause with NOP, masks and enable high
            ST_PAUSE: begin
               cnt_r <= cnt_r + 32'h0000_0001;
               if (cnt_r == 32'(PAUSE_CYC - 1)) begin
                  state_r <= ST_PRE;
               end
            end
            ST_PRE: begin
               state_r  <= ST_WAIT;
               cnt_r    <= '0;
               refCnt_r <= '0;
            end
            // R9 eight auto refreshes
            ST_REF: begin
               state_r  <= ST_WAIT;
               cnt_r    <= '0;
               refCnt_r <= refCnt_r + 4'h1;
            end
            ST_WAIT: begin
               cnt_r <= cnt_r + 32'h0000_0001;
               if (cnt_r == 32'(REF_GAP - 1)) begin
                  state_r <= (refCnt_r == 4'(REF_NUM)) ? ST_MRS : ST_REF;
               end
            end
            // R10 R12 mode set after precharge with enable high
            ST_MRS:  state_r <= ST_MNOP;
            // R13 NOP after mode set
            ST_MNOP: state_r <= ST_READY;
            ST_READY: state_r <= ST_READY;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Pin drive
   // R5 R6 NOP until sequence issues commands
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cke_r     <= 1'b1;
         cmd_r     <= CMD_NOP;
         ba_r      <= '0;
         pinAddr_r <= '0;
         dqm_r     <= `SDRM_MASK_HI;
         dqOe_r    <= 1'b0;
         lastMrs_r <= 1'b0;
      end else begin
         cke_r     <= 1'b1;
         cmd_r     <= CMD_NOP;
         dqOe_r    <= 1'b0;
         lastMrs_r <= 1'b0;
         case (state_r)
            ST_PRE: begin
               cmd_r     <= CMD_PRE;
               pinAddr_r <= 13'h0400;
            end
            ST_REF:  cmd_r <= CMD_REF;
            // R14 R15 mode word on address, bank zero
            ST_MRS: begin
               cmd_r     <= CMD_MRS;
               ba_r      <= `SDRM_BA_MODE;
               pinAddr_r <= mode_r;
            end
            // R11 activates only possible once ready
            ST_READY: begin
               if (cmdWr) begin
                  cmd_r     <= regWdata[`SDRM_CMD_CODE];
                  ba_r      <= regWdata[`SDRM_CMD_BA];
                  dqm_r     <= regWdata[`SDRM_CMD_DQM];
                  pinAddr_r <= addrReg_r;
                  dqOe_r    <= regWdata[`SDRM_CMD_CODE] == CMD_WR;
                  lastMrs_r <= regWdata[`SDRM_CMD_CODE] == CMD_MRS;
               end
            end
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Read capture at programmed latency
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdCnt_r   <= '0;
         rdat_r    <= '0;
         rdValid_r <= 1'b0;
      end else begin
         if (cmdWr && regWdata[`SDRM_CMD_CODE] == CMD_RD) begin
            rdCnt_r   <= mode_r[`SDRM_F_CL] + 3'h1;
            rdValid_r <= 1'b0;
         end else if (rdCnt_r != '0) begin
            rdCnt_r <= rdCnt_r - 3'h1;
         end
         if (rdCnt_r == 3'h1) begin
            rdat_r    <= bus.dqBus;
            rdValid_r <= 1'b1;
         end
      end
   end

   assign bus.cke           = cke_r;
   assign bus.csN           = 1'b0;
   assign {bus.rasN, bus.casN, bus.weN} = cmd_r;
   assign bus.ba            = ba_r;
   assign bus.addr          = pinAddr_r;
   assign bus.upperByteMask = dqm_r[1];
   assign bus.lowerByteMask = dqm_r[0];
   assign bus.dqCtrl        = wdat_r;
   assign bus.dqCtrlOe      = dqOe_r;
endmodule : sdrm_ctrl
`default_nettype wire

// ===== src/sdrm_none_placeholder_unused.sv
// Intentionally empty file not used
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== test/sdrm_props.sv
// Link checker for the SDRAM controller and device pair
`timescale 1ns/1ps
`default_nettype none
module sdrm_props
   import sdrm_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        cke,
   input wire logic        csN,
   input wire logic        rasN,
   input wire logic        casN,
   input wire logic        weN,
   input wire logic [1:0]  ba,
   input wire logic [12:0] addr,
   input wire logic        upperByteMask,
   input wire logic        lowerByteMask,
   input wire logic [1:0]  dqDevOe,
   input wire logic [12:0] modeWord,
   input wire logic        modeValid,
   input wire logic [3:0]  bankOpen
);
   // ==========================================================
   // Command decode and history
   localparam int REF_MIN = 8;
   logic       vld;
   sdrm_cmd_t  cmd;
   logic       seenPre_r;
   logic [3:0] refCnt_r;
   assign vld = !csN && cke;
   assign cmd = sdrm_cmd_t'({rasN, casN, weN});
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         seenPre_r <= 1'h0;
      end else if (vld && cmd == CMD_PRE) begin
         seenPre_r <= 1'h1;
      end
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         refCnt_r <= 4'h0;
      end else if (vld && cmd == CMD_REF && refCnt_r != 4'hF) begin
         refCnt_r <= refCnt_r + 4'h1;
      end
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_mrs;
      vld && cmd == CMD_MRS;
   endsequence
   sequence s_mrs_main;
      vld && cmd == CMD_MRS && ba == 2'h0;
   endsequence
   sequence s_rd_cl2;
      vld && cmd == CMD_RD && modeWord[6:4] == 3'h2 &&
      !upperByteMask && !lowerByteMask;
   endsequence
   a_powerup_quiet: assert property (
      !seenPre_r && !(vld && cmd == CMD_PRE) |->
      cmd == CMD_NOP && cke && upperByteMask && lowerByteMask)
      else $error("command or mask active before precharge");
   a_mrs_nop: assert property (s_mrs |=> cmd == CMD_NOP)
      else $error("mode set not followed by nop");
   a_mode_load: assert property (
      s_mrs_main |=> modeWord == $past(addr))
      else $error("mode word not loaded from address");
   a_mode_bank: assert property (
      vld && cmd == CMD_MRS && ba != 2'h0 |=> $stable(modeWord))
      else $error("mode word changed with nonzero bank");
   a_ref_count: assert property (
      vld && cmd == CMD_MRS && !modeValid |-> refCnt_r >= REF_MIN)
      else $error("first mode set before eight refreshes");
   a_act_order: assert property (vld && cmd == CMD_ACT |-> modeValid)
      else $error("activate before mode set");
   a_mrs_ready: assert property (
      s_mrs |-> bankOpen == 4'h0 && $past(cke))
      else $error("mode set with open bank or clock disabled");
   a_read_lat: assert property (s_rd_cl2 |-> ##2 dqDevOe == 2'h3)
      else $error("read data not driven at latency two");
   a_upper_mask: assert property (
      dqDevOe[1] |-> !$past(upperByteMask, 2))
      else $error("upper lane driven while masked");
   a_lower_mask: assert property (
      dqDevOe[0] |-> !$past(lowerByteMask, 2))
      else $error("lower lane driven while masked");
endmodule : sdrm_props
`default_nettype wire

// ===== test/testbench.sv
// Testbench joining controller and device across the link
`timescale 1ns/1ps
`default_nettype none
`include "sdrm_cfg.svh"
module testbench
   import sdrm_pkg::*;
;
   logic        sys_clk;
   logic        resetn;
   logic [7:0]  regAddr;
   logic [31:0] regWdata;
   logic        regWr;
   logic        regRd;
   logic [31:0] regRdata;
   logic [12:0] modeWord;
   logic        modeValid;
   logic        modeReserved;
   logic [3:0]  bankOpen;
   logic        rdPend = 1'h0;
   logic [31:0] expQ[$];
   logic [31:0] expV;
   logic [15:0] seed;
   logic [15:0] d1;
   logic [15:0] d2;
   int          n_errors;
   int          comparisons;
   logic [12:0] words[10] = '{13'h0021, 13'h0023, 13'h0027, 13'h002F,
      13'h0024, 13'h0030, 13'h0040, 13'h0220, 13'h0080, 13'h0020};
   // ==========================================================
   // Design under test
   sdrm_if sdrm_if_inst();
   sdrm_ctrl #(.PAUSE_CYC(20)) sdrm_ctrl_inst (.sys_clk(sys_clk),
      .resetn(resetn), .bus(sdrm_if_inst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata));
   sdrm_device #(.ROW_W(4)) sdrm_device_inst (.sys_clk(sys_clk),
      .resetn(resetn), .bus(sdrm_if_inst), .modeWord(modeWord),
      .modeValid(modeValid), .modeReserved(modeReserved),
      .bankOpen(bankOpen));
   sdrm_props sdrm_props_inst (.sys_clk(sys_clk), .resetn(resetn),
      .cke(sdrm_if_inst.cke), .csN(sdrm_if_inst.csN),
      .rasN(sdrm_if_inst.rasN), .casN(sdrm_if_inst.casN),
      .weN(sdrm_if_inst.weN), .ba(sdrm_if_inst.ba),
      .addr(sdrm_if_inst.addr), .upperByteMask(sdrm_if_inst.upperByteMask),
      .lowerByteMask(sdrm_if_inst.lowerByteMask),
      .dqDevOe(sdrm_if_inst.dqDevOe), .modeWord(modeWord),
      .modeValid(modeValid), .bankOpen(bankOpen));
   // ==========================================================
   // Helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic resv(input logic [12:0] w);
      return !(w[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7}) ||
         (w[2:0] == 3'h7 && w[3]) || !(w[6:4] inside {3'h2, 3'h3}) ||
         !(w[12:7] inside {6'h00, 6'h04});
   endfunction : resv
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'h1;
      @(posedge sys_clk);
      regWr    <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      regAddr <= a;
      regRd   <= 1'h1;
      expQ.push_back(e);
      @(posedge sys_clk);
      regRd   <= 1'h0;
   endtask : rd
   task automatic issue(input sdrm_cmd_t c, input logic [1:0] b,
                        input logic [1:0] m, input logic [12:0] a);
      wr(`SDRM_REG_ADDR, {19'h0, a});
      wr(`SDRM_REG_CMD, {25'h0, m, b, c});
   endtask : issue
   task final_report;
      $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   // ==========================================================
   // Clock, monitor and watchdog
   initial begin
      sys_clk = 1'h0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (rdPend) begin
         expV = expQ.pop_front();
         check(regRdata, expV);
      end
      rdPend <= regRd;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      final_report();
   end
   // ==========================================================
   // Main sequence
   initial begin
      resetn = 1'h0;
      regAddr = 8'h00;
      regWdata = 32'h0000_0000;
      regWr = 1'h0;
      regRd = 1'h0;
      seed = 16'h0043;
      repeat (16) @(posedge sys_clk);
      resetn <= 1'h1;
      wr(`SDRM_REG_MODE, 32'h0000_0020);
      wr(`SDRM_REG_CTRL, 32'h0000_0001);
      rd(`SDRM_REG_STAT, 32'h0000_0001);
      for (int i = 0; i < 400 && modeValid !== 1'h1; i++) @(posedge sys_clk);
      check({31'h0, modeValid}, 32'h0000_0001);
      check({19'h0, modeWord}, 32'h0000_0020);
      repeat (4) @(posedge sys_clk);
      rd(`SDRM_REG_STAT, 32'h0000_0002);
      foreach (words[i]) begin
         issue(CMD_MRS, 2'h0, 2'h3, words[i]);
         repeat (3) @(posedge sys_clk);
         check({19'h0, modeWord}, {19'h0, words[i]});
         check({31'h0, modeReserved}, {31'h0, resv(words[i])});
      end
      issue(CMD_MRS, 2'h1, 2'h3, 13'h0155);
      repeat (3) @(posedge sys_clk);
      check({19'h0, modeWord}, 32'h0000_0020);
      seed = lfsr(seed);
      d1 = seed;
      seed = lfsr(seed);
      d2 = seed;
      issue(CMD_ACT, 2'h0, 2'h3, 13'h0000);
      wr(`SDRM_REG_WDAT, {16'h0, d1});
      issue(CMD_WR, 2'h0, 2'h0, 13'h0005);
      wr(`SDRM_REG_WDAT, {16'h0, d2});
      issue(CMD_WR, 2'h0, 2'h1, 13'h0005);
      issue(CMD_RD, 2'h0, 2'h0, 13'h0005);
      repeat (6) @(posedge sys_clk);
      rd(`SDRM_REG_RDAT, {16'h0, d2[15:8], d1[7:0]});
      issue(CMD_RD, 2'h0, 2'h2, 13'h0005);
      repeat (6) @(posedge sys_clk);
      rd(`SDRM_REG_RDAT, {24'h0, d1[7:0]});
      repeat (4) @(posedge sys_clk);
      final_report();
   end
endmodule : testbench
`default_nettype wire
